// >>> common/status_pin_cfg.svh
// constants for the status pin and alarm mask block
// assumes it is included by the top module and the bench only
//
// What this block does
// - unlock pin: tristate at 0, status at 1
// - alarm pin shows combined status when enabled
// - active-clock pin driven with input-one status
// - active-clock enable only under pin selection
// - select source: register field or pin
// - select source ignored unless selection manual
// - active-clock polarity: 0 low, 1 high
// - unlock polarity: 0 low, 1 high
// - alarm polarity: 0 low, 1 high
// - input-two absent alarm masked by its bit
// - input-one absent alarm masked by its bit
// - oscillator absent alarm masked by its bit
// - mask writes never change alarm flags
// - alarm pin active only while enabled
// - unlock and offset alarms masked likewise
`ifndef STATUS_PIN_CFG_SVH
`define STATUS_PIN_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_PIN_ENABLES 8'h14
`define OFS_SELECT_CTRL 8'h15
`define OFS_POLARITY 8'h16
`define OFS_ABSENT_MASKS 8'h17
`define OFS_OTHER_MASKS 8'h18

// ----------------------------------------
// reset values and writable bits
// ----------------------------------------
`define RST_PIN_ENABLES 8'h3E
`define RST_SELECT_CTRL 8'hFF
`define RST_POLARITY 8'hDF
`define RST_ABSENT_MASKS 8'h1F
`define RST_OTHER_MASKS 8'h3F
`define RW_PIN_ENABLES 8'h03
`define RW_SELECT_CTRL 8'h03
`define RW_POLARITY 8'h0B
`define RW_ABSENT_MASKS 8'h07
`define RW_OTHER_MASKS 8'h07

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_ALARM_PIN_EN 0
`define BIT_UNLOCK_PIN_EN 1
`define BIT_SELECT_SOURCE 0
`define BIT_ACTIVE_PIN_EN 1
`define BIT_ALARM_POL 0
`define BIT_UNLOCK_POL 1
`define BIT_ACTIVE_POL 3
`define BIT_OSC_MASK 0
`define BIT_IN1_MASK 1
`define BIT_IN2_MASK 2
`define BIT_UNLOCK_MASK 0
`define BIT_FOS1_MASK 1
`define BIT_FOS2_MASK 2

// ----------------------------------------
// misc
// ----------------------------------------
`define AUTOSEL_MANUAL 2'h0
`define SEL_INPUT_ONE 2'h0
`define SEL_INPUT_TWO 2'h1
`define I2C_DEV_ADDR 7'h68
`define BITS_PER_BYTE 4'h8

`endif

// >>> common/status_pin_pkg.sv
// types for the status pin and alarm mask block
// assumes the cfg header sits beside it
package status_pin_pkg;

	// sticky alarm flags, held by the fault detectors outside
	typedef struct packed {
		logic unlock_flag;
		logic fos2_flag;
		logic fos1_flag;
		logic input_two_absent_flag;
		logic input_one_absent_flag;
		logic oscillator_absent_flag;
	} alarm_flags_t;

	// one tristatable output pin, oe_n low while driving
	typedef struct packed {
		logic level;
		logic oe_n;
	} pin_drive_t;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_REG,
		ST_REG_ACK,
		ST_WRITE,
		ST_WRITE_ACK,
		ST_READ,
		ST_MASTER_ACK
	} i2c_state_t;

endpackage : status_pin_pkg

// >>> hw/bit_sync.sv
// two-flop synchroniser for a group of asynchronous levels
// assumes the reset is already released in this clock domain
`timescale 1ns/1ps
module bit_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_sync
			logic meta_q;
			logic stable_q;
			// meta_q feeds stable_q only
			always_ff @(posedge clk_sys_i or negedge rstn_i) begin
				if (!rstn_i) begin
					meta_q <= 1'b1;
					stable_q <= 1'b1;
				end else begin
					meta_q <= async_i[g];
					stable_q <= meta_q;
				end
			end
			assign sync_o[g] = stable_q;
		end
	endgenerate
endmodule : bit_sync

// >>> hw/status_pin_ctrl.sv
// status pin enables, polarities, clock select source and alarm masks
// reached over a two-wire serial slave; flags come from same-clock logic
`timescale 1ns/1ps
`include "status_pin_cfg.svh"
module status_pin_ctrl
	import status_pin_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `I2C_DEV_ADDR
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// serial register port
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	// alarm sources from the fault detectors, plus status and clock selection inputs
	input wire alarm_flags_t alarm_flags_i,
	input wire logic unlock_alarm_status_i,
	input wire logic input_one_active_status_i,
	input wire logic [1:0] automatic_selection_setting_i,
	input wire logic [1:0] register_clock_select_i,
	// pins
	output logic unlock_output_o,
	output logic unlock_output_oe_n_o,
	output logic alarm_output_pin_o,
	output logic alarm_output_pin_oe_n_o,
	input wire logic select_or_active_pin_i,
	output logic select_or_active_pin_o,
	output logic select_or_active_pin_oe_n_o,
	// chosen input clock for the selection logic, and the registered combined alarm status
	output logic [1:0] selected_clock_o,
	output logic alarm_status_o
);

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] pins_sync;
	logic scl_s;
	logic sda_s;
	logic sel_pin_s;

	bit_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rst_n),
		.async_i({select_or_active_pin_i, sda_i, scl_i}),
		.sync_o(pins_sync)
	);
	assign scl_s = pins_sync[0];
	assign sda_s = pins_sync[1];
	assign sel_pin_s = pins_sync[2];

	// ----------------------------------------
	// bus edge and condition detect
	// ----------------------------------------
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_prev_q;
	assign scl_fall = ~scl_s & scl_prev_q;
	assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0] pin_enables_q;
	logic [7:0] select_ctrl_q;
	logic [7:0] polarity_q;
	logic [7:0] absent_masks_q;
	logic [7:0] other_masks_q;

	// readback: writable bits from storage, the rest show their reset pattern
	function automatic logic [7:0] merge(input logic [7:0] val, input logic [7:0] rw, input logic [7:0] rst);
		merge = (val & rw) | (rst & ~rw);
	endfunction : merge

	function automatic logic [7:0] reg_read(input logic [7:0] addr);
		case (addr)
			`OFS_PIN_ENABLES: reg_read = merge(pin_enables_q, `RW_PIN_ENABLES, `RST_PIN_ENABLES);
			`OFS_SELECT_CTRL: reg_read = merge(select_ctrl_q, `RW_SELECT_CTRL, `RST_SELECT_CTRL);
			`OFS_POLARITY: reg_read = merge(polarity_q, `RW_POLARITY, `RST_POLARITY);
			`OFS_ABSENT_MASKS: reg_read = merge(absent_masks_q, `RW_ABSENT_MASKS, `RST_ABSENT_MASKS);
			`OFS_OTHER_MASKS: reg_read = merge(other_masks_q, `RW_OTHER_MASKS, `RST_OTHER_MASKS);
			default: reg_read = 8'h00;
		endcase
	endfunction : reg_read

	// ----------------------------------------
	// serial slave
	// ----------------------------------------
	i2c_state_t state_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] ptr_q;
	logic rd_mode_q;
	logic master_nack_q;
	logic sda_pull_q;
	logic byte_done;
	logic wr_en;
	logic ptr_load;
	logic ptr_inc;
	logic [7:0] rd_byte;

	// read byte is fetched at the pointer as it stands before the step
	assign rd_byte = reg_read(ptr_q);
	assign byte_done = (bit_cnt_q == `BITS_PER_BYTE);
	assign wr_en = scl_fall & (state_q == ST_WRITE) & byte_done;
	assign ptr_load = scl_fall & (state_q == ST_REG) & byte_done;
	// pointer steps after each written byte and each byte fetched for reading
	assign ptr_inc = wr_en |
		(scl_fall & (state_q == ST_ADDR_ACK) & rd_mode_q) |
		(scl_fall & (state_q == ST_MASTER_ACK) & ~master_nack_q);

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			rd_mode_q <= 1'b0;
			master_nack_q <= 1'b1;
			sda_pull_q <= 1'b0;
		end else if (start_cond) begin
			state_q <= ST_ADDR;
			bit_cnt_q <= 4'h0;
			sda_pull_q <= 1'b0;
		end else if (stop_cond) begin
			state_q <= ST_IDLE;
			sda_pull_q <= 1'b0;
		end else if (scl_rise) begin
			case (state_q)
				ST_ADDR, ST_REG, ST_WRITE, ST_READ: begin
					shift_q <= {shift_q[6:0], sda_s};
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end
				ST_MASTER_ACK: begin
					master_nack_q <= sda_s;
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state_q)
				ST_ADDR: begin
					if (byte_done) begin
						if (shift_q[7:1] == DEV_ADDR) begin
							rd_mode_q <= shift_q[0];
							sda_pull_q <= 1'b1;
							state_q <= ST_ADDR_ACK;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					bit_cnt_q <= 4'h0;
					if (rd_mode_q) begin
						shift_q <= rd_byte;
						sda_pull_q <= ~rd_byte[7];
						state_q <= ST_READ;
					end else begin
						sda_pull_q <= 1'b0;
						state_q <= ST_REG;
					end
				end
				ST_REG: begin
					if (byte_done) begin
						sda_pull_q <= 1'b1;
						state_q <= ST_REG_ACK;
					end
				end
				ST_REG_ACK, ST_WRITE_ACK: begin
					sda_pull_q <= 1'b0;
					bit_cnt_q <= 4'h0;
					state_q <= ST_WRITE;
				end
				ST_WRITE: begin
					if (byte_done) begin
						sda_pull_q <= 1'b1;
						state_q <= ST_WRITE_ACK;
					end
				end
				ST_READ: begin
					if (byte_done) begin
						sda_pull_q <= 1'b0;
						state_q <= ST_MASTER_ACK;
					end else begin
						sda_pull_q <= ~shift_q[7];
					end
				end
				ST_MASTER_ACK: begin
					bit_cnt_q <= 4'h0;
					if (master_nack_q) begin
						state_q <= ST_IDLE;
					end else begin
						shift_q <= rd_byte;
						sda_pull_q <= ~rd_byte[7];
						state_q <= ST_READ;
					end
				end
				default: begin
					sda_pull_q <= 1'b0;
				end
			endcase
		end
	end

	// the pointer survives stop, so a read may follow a write of the offset alone
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= 8'h00;
		end else if (ptr_load) begin
			ptr_q <= shift_q;
		end else if (ptr_inc) begin
			ptr_q <= ptr_q + 8'h01;
		end
	end

	// open drain: level is always low, only the enable moves
	assign sda_o = 1'b0;
	assign sda_oe_n_o = ~sda_pull_q;

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// masks live apart from the flags, so a mask write cannot touch a flag
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_enables_q <= `RST_PIN_ENABLES;
			select_ctrl_q <= `RST_SELECT_CTRL;
			polarity_q <= `RST_POLARITY;
			absent_masks_q <= `RST_ABSENT_MASKS;
			other_masks_q <= `RST_OTHER_MASKS;
		end else if (wr_en) begin
			case (ptr_q)
				`OFS_PIN_ENABLES: pin_enables_q <= merge(shift_q, `RW_PIN_ENABLES, `RST_PIN_ENABLES);
				`OFS_SELECT_CTRL: select_ctrl_q <= merge(shift_q, `RW_SELECT_CTRL, `RST_SELECT_CTRL);
				`OFS_POLARITY: polarity_q <= merge(shift_q, `RW_POLARITY, `RST_POLARITY);
				`OFS_ABSENT_MASKS: absent_masks_q <= merge(shift_q, `RW_ABSENT_MASKS, `RST_ABSENT_MASKS);
				`OFS_OTHER_MASKS: other_masks_q <= merge(shift_q, `RW_OTHER_MASKS, `RST_OTHER_MASKS);
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// alarm combine
	// ----------------------------------------
	logic irq_status;
	logic in2_term;
	logic in1_term;
	logic osc_term;
	logic other_term;

	assign in2_term = alarm_flags_i.input_two_absent_flag & ~absent_masks_q[`BIT_IN2_MASK];
	assign in1_term = alarm_flags_i.input_one_absent_flag & ~absent_masks_q[`BIT_IN1_MASK];
	assign osc_term = alarm_flags_i.oscillator_absent_flag & ~absent_masks_q[`BIT_OSC_MASK];
	assign other_term = (alarm_flags_i.unlock_flag & ~other_masks_q[`BIT_UNLOCK_MASK]) |
		(alarm_flags_i.fos1_flag & ~other_masks_q[`BIT_FOS1_MASK]) |
		(alarm_flags_i.fos2_flag & ~other_masks_q[`BIT_FOS2_MASK]);
	assign irq_status = in2_term | in1_term | osc_term | other_term;

	// ----------------------------------------
	// clock selection
	// ----------------------------------------
	logic manual_sel;
	logic pin_selects;

	assign manual_sel = (automatic_selection_setting_i == `AUTOSEL_MANUAL);
	assign pin_selects = manual_sel & select_ctrl_q[`BIT_SELECT_SOURCE];

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			selected_clock_o <= `SEL_INPUT_ONE;
		end else if (pin_selects) begin
			selected_clock_o <= sel_pin_s ? `SEL_INPUT_TWO : `SEL_INPUT_ONE;
		end else begin
			selected_clock_o <= register_clock_select_i;
		end
	end

	// ----------------------------------------
	// output pins
	// ----------------------------------------
	// registered so the pins never glitch on a mask or polarity change
	pin_drive_t unlock_q;
	pin_drive_t alarm_q;
	pin_drive_t active_q;

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			unlock_q <= '{level: 1'b0, oe_n: 1'b1};
			alarm_q <= '{level: 1'b0, oe_n: 1'b1};
			active_q <= '{level: 1'b0, oe_n: 1'b1};
			alarm_status_o <= 1'b0;
		end else begin
			unlock_q.oe_n <= ~pin_enables_q[`BIT_UNLOCK_PIN_EN];
			unlock_q.level <= ~(unlock_alarm_status_i ^ polarity_q[`BIT_UNLOCK_POL]);
			alarm_q.oe_n <= ~pin_enables_q[`BIT_ALARM_PIN_EN];
			alarm_q.level <= ~(irq_status ^ polarity_q[`BIT_ALARM_POL]);
			active_q.oe_n <= ~(pin_selects & select_ctrl_q[`BIT_ACTIVE_PIN_EN]);
			active_q.level <= ~(input_one_active_status_i ^ polarity_q[`BIT_ACTIVE_POL]);
			alarm_status_o <= irq_status;
		end
	end

	assign unlock_output_o = unlock_q.level;
	assign unlock_output_oe_n_o = unlock_q.oe_n;
	assign alarm_output_pin_o = alarm_q.level;
	assign alarm_output_pin_oe_n_o = alarm_q.oe_n;
	assign select_or_active_pin_o = active_q.level;
	assign select_or_active_pin_oe_n_o = active_q.oe_n;

endmodule : status_pin_ctrl

// >>> test/status_pin_ctrl_sva.sv
// port assertions for the status pin and alarm mask block
// bound to status_pin_ctrl; one clock, active-low async reset
`timescale 1ns/1ps
module status_pin_ctrl_sva import status_pin_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic sda_oe_n_o,
	input wire alarm_flags_t alarm_flags_i,
	input wire logic unlock_alarm_status_i,
	input wire logic input_one_active_status_i,
	input wire logic [1:0] automatic_selection_setting_i,
	input wire logic [1:0] register_clock_select_i,
	input wire logic unlock_output_o,
	input wire logic unlock_output_oe_n_o,
	input wire logic alarm_output_pin_o,
	input wire logic alarm_output_pin_oe_n_o,
	input wire logic select_or_active_pin_o,
	input wire logic select_or_active_pin_oe_n_o,
	input wire logic [1:0] selected_clock_o,
	input wire logic alarm_status_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	// ------
	// pins
	// ------
	property p_unlock_follow;
		$changed(unlock_alarm_status_i) && !unlock_output_oe_n_o |=> $changed(unlock_output_o) || unlock_output_oe_n_o;
	endproperty
	a_unlock_follow: assert property (p_unlock_follow) else $error("unlock pin missed status");
	// a level change needs a status change or a register write just acked
	property p_unlock_cause;
		!unlock_output_oe_n_o && $past(!unlock_output_oe_n_o) && $changed(unlock_output_o)
			|-> $past(unlock_alarm_status_i) != $past(unlock_alarm_status_i, 2) || !$past(sda_oe_n_o);
	endproperty
	a_unlock_cause: assert property (p_unlock_cause) else $error("unlock pin moved alone");
	property p_alarm_follow;
		$changed(alarm_status_o) && !alarm_output_pin_oe_n_o
			|-> ##[0:1] ($changed(alarm_output_pin_o) || alarm_output_pin_oe_n_o);
	endproperty
	a_alarm_follow: assert property (p_alarm_follow) else $error("alarm pin missed status");
	property p_alarm_enable;
		$changed(alarm_output_pin_oe_n_o) |-> !$past(sda_oe_n_o);
	endproperty
	a_alarm_enable: assert property (p_alarm_enable) else $error("alarm enable moved alone");
	property p_no_flag;
		!(|alarm_flags_i) ##1 !(|alarm_flags_i) |-> !alarm_status_o;
	endproperty
	a_no_flag: assert property (p_no_flag) else $error("alarm without flag");
	property p_select_choice;
		(automatic_selection_setting_i == 2'h0) [*2]
			|-> selected_clock_o inside {2'h0, 2'h1, $past(register_clock_select_i)};
	endproperty
	a_select_choice: assert property (p_select_choice) else $error("bad manual selection");
	property p_active_auto_off;
		(automatic_selection_setting_i != 2'h0) [*2] |-> select_or_active_pin_oe_n_o;
	endproperty
	a_active_auto_off: assert property (p_active_auto_off) else $error("active pin driven in auto");
	property p_active_follow;
		$changed(input_one_active_status_i) && !select_or_active_pin_oe_n_o
			|=> $changed(select_or_active_pin_o) || select_or_active_pin_oe_n_o;
	endproperty
	a_active_follow: assert property (p_active_follow) else $error("active pin missed status");
endmodule : status_pin_ctrl_sva

// >>> test/board_pins.sv
// board side of the pins: pull-ups and the shared select/active line
// assumes the host drives SDA open drain and every pin but select/active has a pull-up
`timescale 1ns/1ps
module board_pins (
	input wire logic sda_host_i,
	input wire logic sda_oe_n_i,
	input wire logic sda_lvl_i,
	input wire logic unlock_lvl_i,
	input wire logic unlock_oe_n_i,
	input wire logic alarm_lvl_i,
	input wire logic alarm_oe_n_i,
	input wire logic sel_lvl_i,
	input wire logic sel_oe_n_i,
	input wire logic board_sel_i,
	output logic sda_o,
	output logic unlock_o,
	output logic alarm_o,
	output logic sel_o
);
	// released lines float up, so a tristate looks like a high level
	// the device level only counts while its enable is low
	assign sda_o = sda_host_i & (sda_oe_n_i | sda_lvl_i);
	assign unlock_o = unlock_oe_n_i | unlock_lvl_i;
	assign alarm_o = alarm_oe_n_i | alarm_lvl_i;
	// board only sets the select level while the device lets go
	assign sel_o = sel_oe_n_i ? board_sel_i : sel_lvl_i;
endmodule : board_pins

// >>> test/tb_status_pin_ctrl.sv
// bench for the status pin and alarm mask block
// assumes cfg header and package compiled first; host bit-bangs the serial port
`timescale 1ns/1ps
`include "status_pin_cfg.svh"
module tb_status_pin_ctrl import status_pin_pkg::*; ;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic scl = 1'b1;
	logic sda_m = 1'b1;
	logic ul = 1'b0;
	logic act = 1'b0;
	logic bsel = 1'b0;
	alarm_flags_t fl = '0;
	logic [1:0] asel = 2'h0;
	logic [1:0] rsel = 2'h0;
	logic [7:0] en = 8'h3E;
	logic [7:0] sc = 8'hFF;
	logic [7:0] pol = 8'hDF;
	logic [5:0] mk = 6'h3F;
	logic [7:0] rx;
	logic ack;
	logic sda_oe_n, sda_lv, uo, uoe, ao, aoe, so, soe, sdaw, uw, aw, sw, ast;
	logic [1:0] selc;
	int fails = 0;
	int samples_checked = 0;

	initial forever #5 clk_sys_i = ~clk_sys_i;

	status_pin_ctrl u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sdaw), .sda_o(sda_lv),
		.sda_oe_n_o(sda_oe_n), .alarm_flags_i(fl), .unlock_alarm_status_i(ul),
		.input_one_active_status_i(act), .automatic_selection_setting_i(asel),
		.register_clock_select_i(rsel), .unlock_output_o(uo), .unlock_output_oe_n_o(uoe),
		.alarm_output_pin_o(ao), .alarm_output_pin_oe_n_o(aoe), .select_or_active_pin_i(sw),
		.select_or_active_pin_o(so), .select_or_active_pin_oe_n_o(soe), .selected_clock_o(selc),
		.alarm_status_o(ast));
	board_pins u_board (.sda_host_i(sda_m), .sda_oe_n_i(sda_oe_n), .sda_lvl_i(sda_lv), .unlock_lvl_i(uo),
		.unlock_oe_n_i(uoe),
		.alarm_lvl_i(ao), .alarm_oe_n_i(aoe), .sel_lvl_i(so), .sel_oe_n_i(soe), .board_sel_i(bsel),
		.sda_o(sdaw), .unlock_o(uw), .alarm_o(aw), .sel_o(sw));

	// ------
	// tasks
	// ------
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	// third of a bit: slow enough for the two-flop input sync
	task hb;
		repeat (8) @(negedge clk_sys_i);
	endtask : hb
	task start;
		sda_m = 1'b1;
		hb;
		scl = 1'b1;
		hb;
		sda_m = 1'b0;
		hb;
		scl = 1'b0;
		hb;
	endtask : start
	task stop;
		sda_m = 1'b0;
		hb;
		scl = 1'b1;
		hb;
		sda_m = 1'b1;
		hb;
	endtask : stop
	task xfer(input logic [7:0] tx, input logic mack);
		for (int i = 7; i >= -1; i--) begin
			sda_m = (i < 0) ? mack : tx[i];
			hb;
			scl = 1'b1;
			hb;
			if (i >= 0) rx[i] = sdaw;
			else ack = sdaw;
			scl = 1'b0;
			hb;
		end
	endtask : xfer
	task wr(input logic [7:0] off, input logic [7:0] d);
		start;
		xfer({`I2C_DEV_ADDR, 1'b0}, 1'b1);
		chk({7'h0, ack}, 8'h00);
		xfer(off, 1'b1);
		xfer(d, 1'b1);
		chk({7'h0, ack}, 8'h00);
		stop;
	endtask : wr
	task rd(input logic [7:0] off, input logic [7:0] exp);
		start;
		xfer({`I2C_DEV_ADDR, 1'b0}, 1'b1);
		xfer(off, 1'b1);
		start;
		xfer({`I2C_DEV_ADDR, 1'b1}, 1'b1);
		xfer(8'hFF, 1'b1);
		stop;
		chk(rx, exp);
	endtask : rd
	// two bytes in one read: master acks the first, so the pointer must step
	task rd_pair(input logic [7:0] off, input logic [15:0] exp);
		start;
		xfer({`I2C_DEV_ADDR, 1'b0}, 1'b1);
		xfer(off, 1'b1);
		start;
		xfer({`I2C_DEV_ADDR, 1'b1}, 1'b1);
		xfer(8'hFF, 1'b0);
		chk(rx, exp[15:8]);
		xfer(8'hFF, 1'b1);
		stop;
		chk(rx, exp[7:0]);
	endtask : rd_pair
	// both mask registers in one burst, so the pointer must step after a write
	task msk(input logic [5:0] k);
		mk = k;
		start;
		xfer({`I2C_DEV_ADDR, 1'b0}, 1'b1);
		xfer(8'h17, 1'b1);
		xfer({5'h0, k[2:0]}, 1'b1);
		chk({7'h0, ack}, 8'h00);
		xfer({5'h0, k[4], k[3], k[5]}, 1'b1);
		chk({7'h0, ack}, 8'h00);
		stop;
	endtask : msk
	task pins;
		logic irq;
		logic s_on;
		logic s_lvl;
		irq = |(fl & ~mk);
		s_on = (asel == 2'h0) && sc[0] && sc[1];
		s_lvl = s_on ? (act ~^ pol[3]) : bsel;
		repeat (6) @(negedge clk_sys_i);
		chk({7'h0, ast}, {7'h0, irq});
		chk({6'h0, uoe, uw}, {6'h0, ~en[1], ~en[1] | (ul ~^ pol[1])});
		chk({6'h0, aoe, aw}, {6'h0, ~en[0], ~en[0] | (irq ~^ pol[0])});
		chk({6'h0, soe, sw}, {6'h0, ~s_on, s_lvl});
		if (asel == 2'h0) chk({6'h0, selc}, {6'h0, sc[0] ? {1'b0, s_lvl} : rsel});
	endtask : pins
	task report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop

	// ------
	// sequence
	// ------
	initial begin
		repeat (5) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		rd(8'h14, 8'h3E);
		rd(8'h15, 8'hFF);
		rd(8'h16, 8'hDF);
		rd(8'h17, 8'h1F);
		rd(8'h40, 8'h00);
		pins;
		start;
		xfer(8'hA0, 1'b1);
		chk({7'h0, ack}, 8'h01);
		stop;
		wr(8'h14, 8'h03);
		en = 8'h03;
		rd(8'h14, 8'h3F);
		// each flag alone: open, masked, open again with the flag intact
		for (int f = 0; f < 6; f++) begin
			fl = 6'h01 << f;
			msk(~(6'h01 << f));
			pins;
			msk(6'h3F);
			pins;
			msk(~(6'h01 << f));
			pins;
		end
		msk(6'h00);
		// counts down so the readback below differs from the reset pattern
		for (int p = 15; p >= 0; p--) begin
			pol = {4'h0, p[2], 1'b0, p[1:0]};
			wr(8'h16, pol);
			ul = p[3];
			act = p[3];
			fl = p[3] ? 6'h3F : 6'h00;
			pins;
		end
		rd(8'h16, {4'hD, pol[3], 1'b1, pol[1:0]});
		for (int j = 0; j < 8; j++) begin
			sc = {6'h0, j[1:0]};
			wr(8'h15, sc);
			asel = {1'b0, j[2]};
			bsel = j[0];
			rsel = 2'h3 - j[1:0];
			act = ~act;
			pins;
		end
		wr(8'h14, 8'h00);
		en = 8'h00;
		pins;
		rstn_i = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		rd_pair(8'h17, 16'h1F3F);
		en = 8'h3E;
		sc = 8'hFF;
		pol = 8'hDF;
		mk = 6'h3F;
		pins;
		report_and_stop;
	end
endmodule : tb_status_pin_ctrl

bind status_pin_ctrl status_pin_ctrl_sva u_sva (.*);
